// >>> design/pin_edge_detect.sv
// synchroniser, optional noise filter and edge detector for the timer input pin
`timescale 1ns/10ps
module pin_edge_detect
  import tmr_core_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       pin_in,
  input  wire logic       op_clk_en,
  input  wire logic       filt_on,
  output logic            level,
  output logic            rise_pulse,
  output logic            fall_pulse
);

  logic sync1_q;
  logic sync2_q;
  logic samp_q;
  logic filt1_q;
  logic filt2_q;
  logic filt_lvl_q;
  logic prev_q;
  logic cur;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // sample on the operation clock; filter needs two equal extra samples
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_q     <= 1'b0;
      filt1_q    <= 1'b0;
      filt2_q    <= 1'b0;
      filt_lvl_q <= 1'b0;
    end else if (op_clk_en) begin
      samp_q  <= sync2_q;
      filt1_q <= samp_q;
      filt2_q <= filt1_q;
      if (filt1_q == filt2_q) begin
        filt_lvl_q <= filt1_q;
      end
    end
  end

  assign cur = filt_on ? filt_lvl_q : samp_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q     <= 1'b0;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end else begin
      prev_q     <= cur;
      rise_pulse <= cur & ~prev_q;
      fall_pulse <= ~cur & prev_q;
    end
  end

  assign level = prev_q;

endmodule : pin_edge_detect

// >>> design/timer_channel_counter_core.sv
// counter core of one timer channel with an AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
module timer_channel_counter_core
  import tmr_core_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        timer_input_pin,
  output logic             channel_interrupt,
  output logic             start_trigger
);

  ////////////////////////////////////////////////////////////////////////
  // bus slave
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [11:0] channel_mode_reg;
  logic [CW-1:0] channel_data_reg;
  logic [CW-1:0] channel_counter;
  logic        channel_enabled_status;
  chan_state_t state_q;
  logic        start_wr;
  logic        stop_wr;
  logic        data_wr;
  logic        cap_ld;
  logic [CW-1:0] cap_val;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel & htrans[1] & hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  assign start_wr = wr_pend_q & (wr_addr_q == OFS_START) & hwdata[0];
  assign stop_wr  = wr_pend_q & (wr_addr_q == OFS_STOP) & hwdata[0];
  assign data_wr  = wr_pend_q & (wr_addr_q == OFS_DATA);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_mode_reg <= CTRL_RST;
    end else if (wr_pend_q && wr_addr_q == OFS_CTRL) begin
      channel_mode_reg <= hwdata[11:0];
    end
  end

  // capture beats a software write in the same cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_data_reg <= DATA_RST;
    end else if (cap_ld) begin
      channel_data_reg <= cap_val;
    end else if (data_wr) begin
      channel_data_reg <= hwdata[CW-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (hready) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (!(hsel && htrans[1] && !hwrite)) begin
        hrdata <= 32'h00000000;
      end else if (haddr[7:0] == OFS_CTRL) begin
        hrdata <= {20'h00000, channel_mode_reg};
      end else if (haddr[7:0] == OFS_DATA) begin
        hrdata <= {{(32-CW){1'b0}}, channel_data_reg};
      end else if (haddr[7:0] == OFS_COUNT) begin
        hrdata <= {{(32-CW){1'b0}}, channel_counter};
      end else if (haddr[7:0] == OFS_STATUS) begin
        hrdata <= {29'h00000000, state_q, channel_enabled_status};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control fields
  mode_t       mode;
  logic        start_interrupt_mode_bit;
  logic        count_clock_source_sel;
  logic [1:0]  edge_sel;
  logic        filt_on;
  logic [PRESC_W-1:0] operation_clock_sel;

  assign mode                     = mode_t'(channel_mode_reg[CTRL_MODE_LSB +: 3]);
  assign start_interrupt_mode_bit = channel_mode_reg[CTRL_MD0_BIT];
  assign count_clock_source_sel   = channel_mode_reg[CTRL_CCS_BIT];
  assign edge_sel                 = channel_mode_reg[CTRL_EDGE_LSB +: 2];
  assign filt_on                  = channel_mode_reg[CTRL_NF_BIT];
  assign operation_clock_sel      = channel_mode_reg[CTRL_PRESC_LSB +: PRESC_W];

  ////////////////////////////////////////////////////////////////////////
  // prescaler
  logic [PRESC_MAX_EXP-1:0] div_q;
  logic [PRESC_MAX_EXP-1:0] div_mask;
  logic                     op_clk_en;

  assign div_mask = PRESC_MAX_EXP'((16'h0001 << operation_clock_sel) - 16'h0001);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= '0;
    end else if ((div_q & div_mask) == div_mask) begin
      div_q <= '0;
    end else begin
      div_q <= PRESC_MAX_EXP'(div_q + 1'b1);
    end
  end

  // one-cycle high per divided period; undivided stays high
  assign op_clk_en = ((div_q & div_mask) == div_mask);

  ////////////////////////////////////////////////////////////////////////
  // input pin edges
  logic pin_rise;
  logic pin_fall;
  logic pin_valid;

  pin_edge_detect u_edge (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .pin_in     (timer_input_pin),
    .op_clk_en  (op_clk_en),
    .filt_on    (filt_on),
    .level      (),
    .rise_pulse (pin_rise),
    .fall_pulse (pin_fall)
  );

  always_comb begin
    if (edge_sel == EDGE_RISE) begin
      pin_valid = pin_rise;
    end else if (edge_sel == EDGE_BOTH) begin
      pin_valid = pin_rise | pin_fall;
    end else begin
      pin_valid = pin_fall;
    end
  end

  logic tclk;
  assign tclk = count_clock_source_sel ? pin_valid : op_clk_en;

  ////////////////////////////////////////////////////////////////////////
  // channel sequencer and counter
  logic one_mode;
  logic cnt_zero;

  assign one_mode = (mode == MODE_ONECOUNT) || (mode == MODE_CAP_ONE);
  assign cnt_zero = (channel_counter == CNT_ZERO);
  assign cap_val  = channel_counter;
  assign cap_ld   = (state_q == ST_COUNT) &&
                    (((mode == MODE_CAPTURE) && pin_valid) ||
                     ((mode == MODE_CAP_ONE) && pin_fall));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_enabled_status <= 1'b0;
    end else if (stop_wr) begin
      channel_enabled_status <= 1'b0;
    end else if (start_wr) begin
      channel_enabled_status <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q         <= ST_STOP;
      channel_counter   <= CNT_RST;
      channel_interrupt <= 1'b0;
      start_trigger     <= 1'b0;
    end else begin
      // pulses drop unless a branch below raises them
      channel_interrupt <= 1'b0;
      start_trigger     <= 1'b0;
      if (stop_wr) begin
        state_q <= ST_STOP;
      end else if (start_wr && mode == MODE_EVENT) begin
        state_q         <= ST_COUNT;
        channel_counter <= channel_data_reg;
      end else if (start_wr && one_mode) begin
        if (!channel_enabled_status) begin
          state_q <= ST_WAIT;
        end
      end else if (start_wr) begin
        state_q <= ST_WAIT;
      end else begin
        case (state_q)
          ST_WAIT: begin
            if (one_mode ? pin_rise : tclk) begin
              start_trigger     <= 1'b1;
              channel_interrupt <= start_interrupt_mode_bit;
              state_q <= ST_COUNT;
              if (mode == MODE_CAPTURE || mode == MODE_CAP_ONE) begin
                channel_counter <= CNT_ZERO;
              end else begin
                channel_counter <= channel_data_reg;
              end
            end
          end
          ST_COUNT: begin
            if (mode == MODE_CAPTURE && cap_ld) begin
              channel_interrupt <= 1'b1;
              channel_counter <= CNT_ZERO;
            end else if (mode == MODE_CAP_ONE && cap_ld) begin
              channel_interrupt <= 1'b1;
              state_q <= ST_IDLE;
            end else if (tclk) begin
              if (mode == MODE_CAPTURE || mode == MODE_CAP_ONE) begin
                channel_counter <= CW'(channel_counter + 1'b1);
              end else if (mode == MODE_ONECOUNT && cnt_zero) begin
                channel_interrupt <= 1'b1;
                channel_counter <= CNT_STOPVAL;
                state_q         <= ST_WAIT;
              end else if (cnt_zero) begin
                channel_interrupt <= 1'b1;
                channel_counter <= channel_data_reg;
              end else begin
                channel_counter <= CW'(channel_counter - 1'b1);
              end
            end
          end
          ST_IDLE: begin
            if (pin_rise) begin
              state_q         <= ST_COUNT;
              start_trigger   <= 1'b1;
              channel_counter <= CNT_ZERO;
            end
          end
          default: begin
            state_q <= ST_STOP;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_wait_tclk;
    (state_q == ST_WAIT) && !one_mode && tclk && !start_wr && !stop_wr;
  endsequence

  chk_irq_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_b)
    channel_interrupt |=> !channel_interrupt)
    else $error("interrupt wider than one cycle");

  chk_trig_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_b)
    start_trigger |=> !start_trigger)
    else $error("start trigger wider than one cycle");

  chk_first_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_wait_tclk and (mode == MODE_INTERVAL) |=> channel_counter == $past(channel_data_reg) && start_trigger)
    else $error("interval first load wrong");

  chk_start_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_wait_tclk and start_interrupt_mode_bit |=> channel_interrupt)
    else $error("start interrupt missing");

  chk_reload: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_COUNT) && mode == MODE_INTERVAL && tclk && cnt_zero && !start_wr && !stop_wr
    |=> channel_interrupt && channel_counter == $past(channel_data_reg))
    else $error("interval reload wrong");

  chk_event_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    start_wr && !stop_wr && mode == MODE_EVENT |=> channel_counter == $past(channel_data_reg))
    else $error("event load wrong");

  chk_hold_stop: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_STOP) && !start_wr |=> $stable(channel_counter))
    else $error("counter moved while stopped");

  chk_capture: assert property (@(posedge core_clk) disable iff (!rst_b)
    cap_ld && mode == MODE_CAPTURE && !stop_wr && !start_wr
    |=> channel_data_reg == $past(channel_counter) && channel_counter == CNT_ZERO && channel_interrupt)
    else $error("capture wrong");

  chk_one_end: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_COUNT) && mode == MODE_ONECOUNT && tclk && cnt_zero && !start_wr && !stop_wr
    |=> channel_counter == CNT_STOPVAL && channel_interrupt ##1 $stable(channel_counter))
    else $error("one-count end wrong");

  chk_capture_start: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_wait_tclk and (mode == MODE_CAPTURE) |=> channel_counter == CNT_ZERO && start_trigger)
    else $error("capture start wrong");

  chk_one_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
    start_wr && !stop_wr && one_mode && !channel_enabled_status |=> state_q == ST_WAIT)
    else $error("one-count start did not wait");

  chk_one_trigger: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_WAIT) && mode == MODE_ONECOUNT && pin_rise && !start_wr && !stop_wr
    |=> channel_counter == $past(channel_data_reg) && start_trigger)
    else $error("one-count trigger load wrong");

  chk_cap_one: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_COUNT) && mode == MODE_CAP_ONE && cap_ld && !start_wr && !stop_wr
    |=> channel_data_reg == $past(channel_counter) && channel_interrupt && state_q == ST_IDLE)
    else $error("high width capture wrong");

  chk_div_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_clk_en && (operation_clock_sel != '0) && !(wr_pend_q && wr_addr_q == OFS_CTRL)
    |=> !op_clk_en)
    else $error("divided operation clock wider than one cycle");

endmodule : timer_channel_counter_core

// >>> design/tmr_core_pkg.sv
// shared constants for the timer channel counter core
package tmr_core_pkg;

  localparam int          CNT_W          = 16;
  localparam int          PRESC_W        = 4;
  localparam int          PRESC_MAX_EXP  = 15;
  localparam logic [15:0] CNT_RST        = 16'h0000;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_STOPVAL    = 16'hFFFF;
  localparam logic [15:0] DATA_RST       = 16'h0000;

  // bus map of the channel registers
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_START  = 8'h04;
  localparam logic [7:0] OFS_STOP   = 8'h08;
  localparam logic [7:0] OFS_DATA   = 8'h0C;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_MD0_BIT   = 3;
  localparam int CTRL_CCS_BIT   = 4;
  localparam int CTRL_EDGE_LSB  = 5;
  localparam int CTRL_NF_BIT    = 7;
  localparam int CTRL_PRESC_LSB = 8;
  localparam logic [11:0] CTRL_RST = 12'h000;

  // edge selection for pin counting
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef enum logic [2:0] {
    MODE_INTERVAL = 3'b000,
    MODE_EVENT    = 3'b001,
    MODE_CAPTURE  = 3'b010,
    MODE_ONECOUNT = 3'b011,
    MODE_CAP_ONE  = 3'b100
  } mode_t;

  typedef enum logic [1:0] {
    ST_STOP  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_COUNT = 2'b10,
    ST_IDLE  = 2'b11
  } chan_state_t;

endpackage : tmr_core_pkg

// >>> dv/pulse_source_model.sv
// behavioural pulse source that drives the timer input pin
`timescale 1ns/10ps
module pulse_source_model (
  input  wire logic core_clk,
  output logic      pin
);
  localparam int MIN_HOLD = 2;

  initial pin = 1'b0;

  // each level is held for at least two core clocks before the next change
  task automatic drive(input logic lvl, input int hold);
    @(posedge core_clk);
    pin <= lvl;
    repeat ((hold < MIN_HOLD) ? MIN_HOLD - 1 : hold - 1) @(posedge core_clk);
  endtask : drive

  task automatic pulses(input int n, input int hold);
    repeat (n) begin
      drive(1'b1, hold);
      drive(1'b0, hold);
    end
  endtask : pulses
endmodule : pulse_source_model

// >>> dv/timer_channel_counter_core_tb_top.sv
// self-checking testbench of the timer channel counter core
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module timer_channel_counter_core_tb_top
  import tmr_core_pkg::*;
;
  logic        core_clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hreadyout;
  wire logic   hresp;
  wire logic [31:0] hrdata;
  wire logic   timer_input_pin;
  wire logic   channel_interrupt;
  wire logic   start_trigger;
  int          n_errors;
  int          comparisons;
  int          n_int;
  logic        int_q;
  logic        trg_q;
  logic [31:0] x;
  int          n;
  int          base;
  int          base_t;
  int          n_trg;
  int          n_trg_int;

  timer_channel_counter_core timer_channel_counter_core_i (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .timer_input_pin(timer_input_pin), .channel_interrupt(channel_interrupt),
    .start_trigger(start_trigger));

  pulse_source_model pulse_source_model_i (.core_clk(core_clk), .pin(timer_input_pin));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse monitor
  always @(posedge core_clk) begin
    int_q <= channel_interrupt;
    trg_q <= start_trigger;
    if (channel_interrupt === 1'b1) n_int++;
    if (start_trigger === 1'b1) n_trg++;
    if (start_trigger === 1'b1 && channel_interrupt === 1'b1) n_trg_int++;
    if (rst_b === 1'b1) begin
      `CHK("int_width", 1'b0, int_q & channel_interrupt)
      `CHK("trg_width", 1'b0, trg_q & start_trigger)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h000000, ofs};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : bus

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, ofs, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] ex, input string nm);
    logic [31:0] r;
    bus(1'b0, ofs, 32'h00000000, r);
    `CHK(nm, ex, r)
  endtask : rd_chk

  task automatic wait_int(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (channel_interrupt !== 1'b1 && c < 3000);
    if (channel_interrupt !== 1'b1) n_errors++;
  endtask : wait_int

  function automatic logic [31:0] ctrl(input mode_t m, input logic md0, input logic ccs, input logic [1:0] edg,
                                       input logic nf, input logic [3:0] ex);
    return {20'h00000, ex, nf, edg, ccs, md0, m};
  endfunction : ctrl

  task automatic restart(input logic [31:0] c, input logic [31:0] d);
    wr(OFS_STOP, 32'h00000001);
    wr(OFS_DATA, d);
    wr(OFS_CTRL, c);
    wr(OFS_START, 32'h00000001);
  endtask : restart

  task automatic results;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0; hsize = 3'h2; rst_b = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk(OFS_CTRL, 32'h0, "ctrl_rst");
    rd_chk(OFS_STATUS, 32'h0, "status_rst");
    rd_chk(OFS_COUNT, 32'h0, "count_rst");
    wr(8'h18, 32'hFFFFFFFF);
    rd_chk(8'h18, 32'h0, "unmapped");
    wr(OFS_COUNT, 32'h00005555);
    rd_chk(OFS_COUNT, 32'h0, "count_ro");
    wr(OFS_DATA, 32'h00001234);
    rd_chk(OFS_DATA, 32'h00001234, "data_rw");
    // interval with start interrupt, undivided and divided prescaler
    for (int e = 0; e <= 2; e += 2) begin
      base   = n_trg_int;
      base_t = n_trg;
      restart(ctrl(MODE_INTERVAL, 1'b1, 1'b0, EDGE_RISE, 1'b0, 4'(e)), 32'h3);
      bus(1'b0, OFS_STATUS, 32'h0, x);
      `CHK("enabled", 1'b1, x[0])
      // the trigger may already have passed during the status read
      n = 0;
      while (start_trigger !== 1'b1 && n_trg == base_t && n < 100) begin
        @(posedge core_clk);
        n++;
      end
      repeat (2) @(posedge core_clk);
      `CHK("start_trg", base_t + 1, n_trg)
      `CHK("start_int", base + 1, n_trg_int)
      wait_int(n);
      wait_int(n);
      `CHK("interval_gap", 4 << e, n)
    end
    wr(OFS_STOP, 32'h00000001);
    bus(1'b0, OFS_COUNT, 32'h0, x);
    repeat (10) @(posedge core_clk);
    rd_chk(OFS_COUNT, x, "count_hold");
    // event counter over rising, both and falling edge codes
    restart(ctrl(MODE_EVENT, 1'b0, 1'b1, EDGE_RISE, 1'b0, 4'h2), 32'h5);
    rd_chk(OFS_COUNT, 32'h5, "event_load");
    pulse_source_model_i.pulses(3, 16);
    repeat (16) @(posedge core_clk);
    rd_chk(OFS_COUNT, 32'h2, "event_rise");
    restart(ctrl(MODE_EVENT, 1'b0, 1'b1, EDGE_BOTH, 1'b1, 4'h1), 32'h5);
    pulse_source_model_i.pulses(2, 16);
    repeat (16) @(posedge core_clk);
    rd_chk(OFS_COUNT, 32'h1, "event_both_filt");
    restart(ctrl(MODE_EVENT, 1'b0, 1'b1, EDGE_FALL, 1'b0, 4'h0), 32'h5);
    pulse_source_model_i.pulses(1, 8);
    repeat (8) @(posedge core_clk);
    rd_chk(OFS_COUNT, 32'h4, "event_fall");
    // capture of a 20 cycle pulse interval
    base = n_int;
    restart(ctrl(MODE_CAPTURE, 1'b0, 1'b0, EDGE_RISE, 1'b0, 4'h0), 32'h0);
    pulse_source_model_i.pulses(3, 10);
    repeat (8) @(posedge core_clk);
    `CHK("capture_ints", base + 3, n_int)
    bus(1'b0, OFS_DATA, 32'h0, x);
    `CHK("capture_val", 1'b1, x >= 32'd18 && x <= 32'd20)
    // one-count, retriggered once
    wr(OFS_STOP, 32'h00000001);
    restart(ctrl(MODE_ONECOUNT, 1'b0, 1'b0, EDGE_RISE, 1'b0, 4'h0), 32'h6);
    bus(1'b0, OFS_STATUS, 32'h0, x);
    `CHK("wait_state", 2'h1, x[2:1])
    for (int k = 0; k < 2; k++) begin
      base = n_int;
      pulse_source_model_i.pulses(1, 4);
      repeat (30) @(posedge core_clk);
      `CHK("one_ints", base + 1, n_int)
      rd_chk(OFS_COUNT, 32'h0000FFFF, "one_stop");
    end
    // capture plus one-count, high width 30 with filter
    restart(ctrl(MODE_CAP_ONE, 1'b0, 1'b0, EDGE_RISE, 1'b1, 4'h0), 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0, x);
    `CHK("cap_one_wait", 2'h1, x[2:1])
    pulse_source_model_i.drive(1'b1, 30);
    pulse_source_model_i.drive(1'b0, 4);
    wait_int(n);
    `CHK("cap_one_int", 1'b1, n < 20)
    bus(1'b0, OFS_DATA, 32'h0, x);
    `CHK("cap_one_width", 1'b1, x >= 32'd28 && x <= 32'd31)
    // a new rise after the capture measures again
    pulse_source_model_i.drive(1'b1, 20);
    pulse_source_model_i.drive(1'b0, 4);
    wait_int(n);
    bus(1'b0, OFS_DATA, 32'h0, x);
    `CHK("cap_one_again", 1'b1, x >= 32'd18 && x <= 32'd21)
    wr(OFS_STOP, 32'h00000001);
    rd_chk(OFS_STATUS, 32'h0, "stopped");
    results();
  end
endmodule : timer_channel_counter_core_tb_top
